// [bench/hpf_host_model.sv]
// host processor model that drives the parallel port pins
`timescale 1ns/1ns
module hpf_host_model
(
  input  wire logic       clk,
  input  wire logic [7:0] din,
  input  wire logic       oe_n,
  output logic            sel1_n,
  output logic            sel2_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            addr,
  output logic      [7:0] data
);
  // idle bus: nothing selected, no strobe
  initial {sel1_n, sel2_n, rd_n, wr_n, addr, data} = 13'h1e00;
  // one access; selects and data settle 3 clocks before the strobe
  task automatic xfer(input logic c2, w, a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    sel1_n <= c2;
    sel2_n <= !c2;
    addr   <= a;
    data   <= d;
    repeat (3) @(posedge clk);
    // only one strobe at a time
    if (w) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    // an undriven bus reads back as garbage, so the enable is checked too
    q = oe_n ? ~din : din;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (4) @(posedge clk);
    sel1_n <= 1'b1;
    sel2_n <= 1'b1;
    // a released bus must not keep showing the old byte
    data <= ~d;
    repeat (3) @(posedge clk);
  endtask
endmodule

// [bench/hpf_host_port_tb.sv]
// self-checking bench for the host port
`timescale 1ns/1ns
module hpf_host_port_tb;
  logic CLK, RST_N, PSEL, PENABLE, PWRITE;
  logic [15:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic PREADY, PSLVERR, S1, S2, RD, WR, HA, DOE, GO, GOE, QA, QB, QC, I1, I2, err;
  logic [7:0] HD, DO, hq;
  int fails = 0;
  int comparisons = 0;
  hpf_host_model hm (.clk(CLK), .din(DO), .oe_n(DOE), .sel1_n(S1), .sel2_n(S2), .rd_n(RD),
    .wr_n(WR), .addr(HA), .data(HD));
  hpf_host_port dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SELECT_CH1_N(S1), .SELECT_CH2_N(S2), .HOST_READ_N(RD),
    .HOST_WRITE_N(WR), .HOST_ADDR_BIT(HA), .HOST_DATA_IN(HD), .HOST_DATA_OUT(DO),
    .HOST_DATA_OE_N(DOE), .ADDR20_GATE_OUT(GO), .ADDR20_GATE_OE_N(GOE),
    .HOST_REQ_A(QA), .HOST_REQ_B(QB), .HOST_REQ_C(QC), .RX_FULL_IRQ_CH1(I1),
    .RX_FULL_IRQ_CH2(I2));
  // free-running 50 MHz clock
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task automatic complete_run();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t %h %h", $time, e, g);
    end
  endtask
  // apb transfer; entered just after a rising edge, waits a bounded time
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
    end while (!(PREADY === 1'b1) && n < 50);
    q = PRDATA;
    err = PSLVERR;
    if (PREADY !== 1'b1)
    begin
      fails++;
      complete_run();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  // host writes both channels, cpu drains both channels
  task automatic t_write();
    apb(1, hpf_pkg::ADR_IRQ_EN, 32'h0000_0003);
    hm.xfer(0, 1, 0, 8'h5a, hq);
    hm.xfer(1, 1, 1, 8'h33, hq);
    chk({I1, I2}, 2'h3);
    apb(0, hpf_pkg::ADR_STS1, 0);
    chk(q, 8'h02);
    apb(0, hpf_pkg::ADR_STS2, 0);
    chk(q, 8'h0a);
    apb(0, hpf_pkg::ADR_IN2, 0);
    chk(q, 8'h33);
    apb(0, hpf_pkg::ADR_IN1, 0);
    chk(q, 8'h5a);
    chk({I1, I2}, 2'h0);
    chk(DOE, 1'b1);
  endtask
  // host reads status then output data of channel 1
  task automatic t_read();
    apb(1, hpf_pkg::ADR_OUT1, 32'h0000_00a5);
    hm.xfer(0, 0, 1, 8'h00, hq);
    chk(hq, 8'h01);
    hm.xfer(0, 0, 0, 8'h00, hq);
    chk(hq, 8'ha5);
  endtask
  // fast gate command sequences
  task automatic t_gate();
    apb(1, hpf_pkg::ADR_GATE_PIN, 32'h0000_0001);
    chk({GO, GOE}, 2'h0);
    apb(1, hpf_pkg::ADR_GATE_PIN, 32'h0000_0003);
    apb(1, hpf_pkg::ADR_HOST_CTRL, 32'h0000_0001);
    chk({GO, GOE}, 2'h2);
    hm.xfer(0, 1, 1, hpf_pkg::CMD_GATE, hq);
    hm.xfer(0, 1, 0, 8'hfd, hq);
    hm.xfer(0, 1, 1, hpf_pkg::CMD_NOP, hq);
    chk({GO, I1}, 2'h0);
    hm.xfer(0, 1, 1, hpf_pkg::CMD_GATE, hq);
    hm.xfer(0, 1, 1, hpf_pkg::CMD_GATE, hq);
    hm.xfer(0, 1, 0, 8'h02, hq);
    chk({GO, I1}, 2'h2);
    hm.xfer(1, 1, 1, hpf_pkg::CMD_GATE, hq);
    hm.xfer(1, 1, 0, 8'h00, hq);
    chk(GO, 1'b1);
    hm.xfer(0, 1, 1, 8'h20, hq);
    chk({GO, I1}, 2'h3);
  endtask
  // host request latches set by cpu, a and b cleared by a ch1 host read, c by a cpu zero write
  task automatic t_latch();
    apb(0, hpf_pkg::ADR_PORT4, 0);
    chk(err, 1'b0);
    apb(1, hpf_pkg::ADR_PORT4, 32'h0000_0038);
    chk({QA, QB, QC}, 3'h7);
    hm.xfer(0, 0, 0, 8'h00, hq);
    chk({QA, QB, QC}, 3'h1);
    apb(1, hpf_pkg::ADR_PORT4, 32'h0000_0000);
    chk(QC, 1'b0);
    apb(0, 16'hff40, 0);
    chk(q, 0);
    chk(err, 1'b1);
  endtask
  initial
  begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    RST_N = 1'b0;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    apb(1, hpf_pkg::ADR_SYS_CTRL, 32'h0000_0002);
    t_write();
    t_read();
    t_gate();
    t_latch();
    complete_run();
  end
endmodule

// [rtl/hpf_gate.sv]
// fast address-20 gate command decoder
`timescale 1ns/1ns
module hpf_gate
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       wr_pulse,
  input  wire logic       is_cmd,
  input  wire logic [7:0] data,
  input  wire logic       init_val,
  output logic            gate,
  output logic            raise
);
  typedef enum logic [1:0] {G_IDLE, G_ARMED, G_DONE} hpf_gstate_t;
  hpf_gstate_t state_reg;        // position in the command sequence
  logic        is_d1;            // command opens a gate sequence
  logic        is_ff;            // trailing no-op command
  assign is_d1 = is_cmd && (data == hpf_pkg::CMD_GATE);
  assign is_ff = is_cmd && (data == hpf_pkg::CMD_NOP);
  // cpu flag is raised unless the byte belongs to a gate sequence or is a data byte written right after the gate data byte
  always_comb
  begin
    raise = 1'b1;
    if (enable)
    begin
      case (state_reg)
        G_ARMED: raise = is_cmd && !is_d1;
        G_DONE:  raise = is_cmd && !is_d1 && !is_ff;
        default: raise = !is_d1;
      endcase
    end
  end
  // sequence tracking, only written bytes of channel 1 arrive here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= G_IDLE;
    else if (!enable)
      state_reg <= G_IDLE;
    else if (wr_pulse)
    begin
      if (is_d1)
        state_reg <= G_ARMED;
      else if (state_reg == G_ARMED && !is_cmd)
        state_reg <= G_DONE;
      else
        state_reg <= G_IDLE;
    end
  end
  // gate level: seeded from the pin data value while disabled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gate <= 1'b1;
    else if (!enable)
      gate <= init_val;
    else if (wr_pulse && state_reg == G_ARMED && !is_cmd)
      gate <= data[hpf_pkg::GATE_BIT];
  end
  a_gate_follow: assert property (@(posedge clk) disable iff (!rst_n)
    enable && wr_pulse && !is_cmd && state_reg == G_ARMED
    |=> gate == $past(data[hpf_pkg::GATE_BIT]))
    else $error("gate did not follow data bit");
  a_gate_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    enable && wr_pulse && is_d1 |-> !raise)
    else $error("gate command raised the flag");
  a_gate_cancel: assert property (@(posedge clk) disable iff (!rst_n)
    enable && wr_pulse && is_cmd && !is_d1 && state_reg == G_ARMED
    |-> raise ##1 (state_reg == G_IDLE && $stable(gate)))
    else $error("cancel did not raise or moved gate");
  c_gate_turn: cover property (@(posedge clk) disable iff (!rst_n)
    enable && $changed(gate));
endmodule

// [rtl/hpf_host_port.sv]
// host port: two channel parallel slave with fast gate and host requests
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
// ****************************************************************
// Summary of operation
// - port active only while enable bit set
// - slave mode takes over data and strobe pins
// - ch1 read drives output data or status
// - ch1 write loads input data, tagged by address
// - ch2 reads and writes mirror channel 1
// - fast gate output only when enable set
// - gate starts at pin data value, high
// - gate commands only from ch1 writes
// - after d1 command, data bit1 drives gate
// - gate changes at write strobe rising edge
// - gate bytes never raise cpu flag
// - other command cancels; repeated d1 re-arms
// - ch1 full interrupt while enabled and full
// - ch2 full interrupt while enabled and full
// - three port4 bits drive host requests
// - latch sets on read zero then write one
// - cpu writing zero clears the latch
// - ch1 data read clears latches a and b
// - ch2 data read clears latch c
// - full flag set by host, cleared by cpu
// - address level latched into command/data bit
// ****************************************************************
module hpf_host_port
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SELECT_CH1_N,
  input  wire logic        SELECT_CH2_N,
  input  wire logic        HOST_READ_N,
  input  wire logic        HOST_WRITE_N,
  input  wire logic        HOST_ADDR_BIT,
  input  wire logic [7:0]  HOST_DATA_IN,
  output logic      [7:0]  HOST_DATA_OUT,
  output logic             HOST_DATA_OE_N,
  output logic             ADDR20_GATE_OUT,
  output logic             ADDR20_GATE_OE_N,
  output logic             HOST_REQ_A,
  output logic             HOST_REQ_B,
  output logic             HOST_REQ_C,
  output logic             RX_FULL_IRQ_CH1,
  output logic             RX_FULL_IRQ_CH2
);
  // ****************************************************************
  // host pin sampling
  // ****************************************************************
  hpf_pkg::hpf_pins_t pins_raw;   // pins as they arrive
  hpf_pkg::hpf_pins_t hs;         // synchronised sample
  hpf_pkg::hpf_pins_t prev_reg;   // sample one clock earlier
  assign pins_raw = '{SELECT_CH1_N, SELECT_CH2_N, HOST_READ_N,
                      HOST_WRITE_N, HOST_ADDR_BIT, HOST_DATA_IN};
  // two flops before any edge logic looks at the pins
  hpf_sync u_sync
  (
    .clk   (CLK),
    .rst_n (RST_N),
    .din   (pins_raw),
    .dout  (hs)
  );
  // previous sample gives edges; it also holds the address and data
  // that were stable while the write strobe was low
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      prev_reg <= hpf_pkg::PINS_IDLE;
    else
      prev_reg <= hs;
  end
  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0] sys_ctrl_reg;   // system control, host enable
  logic [7:0] host_ctrl_reg;  // host control, fast gate enable
  logic [7:0] irq_en_reg;     // full interrupt enables
  logic [7:0] gate_pin_reg;   // gate pin direction and data value
  logic       host_en;        // slave mode
  logic       fast_en;        // fast gate active
  assign host_en = sys_ctrl_reg[hpf_pkg::HPE_BIT];
  assign fast_en = host_en && host_ctrl_reg[hpf_pkg::FGE_BIT];
  // ****************************************************************
  // host access decode
  // ****************************************************************
  logic ch1_prev;   // ch1 alone selected in the previous sample
  logic ch2_prev;   // ch2 alone selected in the previous sample
  logic ch1_now;    // ch1 alone selected now
  logic ch2_now;    // ch2 alone selected now
  logic wr_rise;    // end of a host write
  logic rd_fall;    // start of a host read
  logic rd_rise;    // end of a host read
  logic wr1;        // host wrote channel 1
  logic wr2;        // host wrote channel 2
  logic rd_active;  // host read in progress
  assign ch1_prev = !prev_reg.sel1_n && prev_reg.sel2_n;
  assign ch2_prev = !prev_reg.sel2_n && prev_reg.sel1_n;
  assign ch1_now  = !hs.sel1_n && hs.sel2_n;
  assign ch2_now  = !hs.sel2_n && hs.sel1_n;
  // the other strobe must be high, so both low reads as idle
  assign wr_rise  = host_en && !prev_reg.wr_n && hs.wr_n && prev_reg.rd_n;
  assign rd_fall  = host_en && prev_reg.rd_n && !hs.rd_n && hs.wr_n;
  assign rd_rise  = host_en && !prev_reg.rd_n && hs.rd_n && prev_reg.wr_n;
  assign wr1      = wr_rise && ch1_prev;
  assign wr2      = wr_rise && ch2_prev;
  assign rd_active = host_en && !hs.rd_n && hs.wr_n && (ch1_now || ch2_now);
  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic setup;       // first cycle of a transfer
  logic acc;         // access phase, completes at once
  logic wr_acc;      // completing write
  logic rd_acc;      // completing read
  logic mapped;      // address hits a register
  logic [7:0] rmux;  // read value of the addressed register
  assign setup  = PSEL && !PENABLE;
  assign acc    = PSEL && PENABLE;
  assign wr_acc = acc && PWRITE;
  assign rd_acc = acc && !PWRITE;
  // no wait states: the read value is captured in setup
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !mapped;
  // ****************************************************************
  // channel data and status
  // ****************************************************************
  logic [7:0] in1_reg;     // in_data_ch1
  logic [7:0] in2_reg;     // in_data_ch2
  logic [7:0] out1_reg;    // out_data_ch1
  logic [7:0] out2_reg;    // out_data_ch2
  logic [7:0] sts1_reg;    // status_ch1
  logic [7:0] sts2_reg;    // status_ch2
  logic [7:0] port4_reg;   // port4_data_reg with host request latches
  logic       raise1;      // ch1 write sets the full flag
  logic       gate_q;      // fast gate level
  // fast gate sees only channel 1 writes
  hpf_gate u_gate
  (
    .clk      (CLK),
    .rst_n    (RST_N),
    .enable   (fast_en),
    .wr_pulse (wr1),
    .is_cmd   (prev_reg.addr),
    .data     (prev_reg.data),
    .init_val (gate_pin_reg[hpf_pkg::DVAL_BIT]),
    .gate     (gate_q),
    .raise    (raise1)
  );
  // input data registers take the byte held during the strobe
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      in1_reg <= hpf_pkg::RST_ZERO;
      in2_reg <= hpf_pkg::RST_ZERO;
    end
    else
    begin
      if (wr1)
        in1_reg <= prev_reg.data;
      if (wr2)
        in2_reg <= prev_reg.data;
    end
  end
  // output data registers written only by the local cpu
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      out1_reg <= hpf_pkg::RST_ZERO;
      out2_reg <= hpf_pkg::RST_ZERO;
    end
    else if (wr_acc)
    begin
      if (PADDR == hpf_pkg::ADR_OUT1)
        out1_reg <= PWDATA[7:0];
      if (PADDR == hpf_pkg::ADR_OUT2)
        out2_reg <= PWDATA[7:0];
    end
  end
  // status: user bits by cpu, flags by hardware; a set beats a
  // clear that lands in the same cycle
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sts1_reg <= hpf_pkg::RST_ZERO;
      sts2_reg <= hpf_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_acc && PADDR == hpf_pkg::ADR_STS1)
        sts1_reg <= (sts1_reg & ~hpf_pkg::STS_USER_MASK)
                  | (PWDATA[7:0] & hpf_pkg::STS_USER_MASK);
      if (wr_acc && PADDR == hpf_pkg::ADR_STS2)
        sts2_reg <= (sts2_reg & ~hpf_pkg::STS_USER_MASK)
                  | (PWDATA[7:0] & hpf_pkg::STS_USER_MASK);
      // channel 1 flags
      if (wr1)
        sts1_reg[hpf_pkg::CD_BIT] <= prev_reg.addr;
      if (wr1 && raise1)
        sts1_reg[hpf_pkg::RXF_BIT] <= 1'b1;
      else if (rd_acc && PADDR == hpf_pkg::ADR_IN1)
        sts1_reg[hpf_pkg::RXF_BIT] <= 1'b0;
      if (wr_acc && PADDR == hpf_pkg::ADR_OUT1)
        sts1_reg[hpf_pkg::TXF_BIT] <= 1'b1;
      else if (rd_rise && ch1_prev && !prev_reg.addr)
        sts1_reg[hpf_pkg::TXF_BIT] <= 1'b0;
      // channel 2 flags
      if (wr2)
        sts2_reg[hpf_pkg::CD_BIT] <= prev_reg.addr;
      if (wr2)
        sts2_reg[hpf_pkg::RXF_BIT] <= 1'b1;
      else if (rd_acc && PADDR == hpf_pkg::ADR_IN2)
        sts2_reg[hpf_pkg::RXF_BIT] <= 1'b0;
      if (wr_acc && PADDR == hpf_pkg::ADR_OUT2)
        sts2_reg[hpf_pkg::TXF_BIT] <= 1'b1;
      else if (rd_rise && ch2_prev && !prev_reg.addr)
        sts2_reg[hpf_pkg::TXF_BIT] <= 1'b0;
    end
  end
  // ****************************************************************
  // control register writes
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sys_ctrl_reg  <= hpf_pkg::RST_ZERO;
      host_ctrl_reg <= hpf_pkg::RST_ZERO;
      irq_en_reg    <= hpf_pkg::RST_ZERO;
      gate_pin_reg  <= hpf_pkg::RST_GATE;
    end
    else if (wr_acc)
    begin
      case (PADDR)
        hpf_pkg::ADR_SYS_CTRL:  sys_ctrl_reg  <= PWDATA[7:0];
        hpf_pkg::ADR_HOST_CTRL: host_ctrl_reg <= PWDATA[7:0];
        hpf_pkg::ADR_IRQ_EN:    irq_en_reg    <= PWDATA[7:0];
        hpf_pkg::ADR_GATE_PIN:  gate_pin_reg  <= PWDATA[7:0];
        default:                sys_ctrl_reg  <= sys_ctrl_reg;
      endcase
    end
  end
  // ****************************************************************
  // host request latches in port4
  // ****************************************************************
  logic [7:0] read0_reg;  // bit was read as zero since last write
  logic [7:0] host_clr;   // host read clears this bit
  always_comb
  begin
    host_clr = 8'h00;
    host_clr[hpf_pkg::REQ_A] = rd_fall && ch1_now && !hs.addr;
    host_clr[hpf_pkg::REQ_B] = rd_fall && ch1_now && !hs.addr;
    host_clr[hpf_pkg::REQ_C] = rd_fall && ch2_now && !hs.addr;
  end
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_p4
      // latch bits need a read of zero before a one takes; others are
      // plain storage
      localparam bit IS_REQ = (gi == hpf_pkg::REQ_A) ||
                              (gi == hpf_pkg::REQ_B) ||
                              (gi == hpf_pkg::REQ_C);
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          port4_reg[gi] <= 1'b0;
          read0_reg[gi] <= 1'b0;
        end
        else if (wr_acc && PADDR == hpf_pkg::ADR_PORT4)
        begin
          read0_reg[gi] <= 1'b0;
          if (!PWDATA[gi])
            port4_reg[gi] <= 1'b0;
          else if (!IS_REQ || read0_reg[gi])
            port4_reg[gi] <= 1'b1;
          else if (host_clr[gi])
            port4_reg[gi] <= 1'b0;
        end
        else
        begin
          if (rd_acc && PADDR == hpf_pkg::ADR_PORT4 && !port4_reg[gi])
            read0_reg[gi] <= 1'b1;
          if (host_clr[gi])
            port4_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  // ****************************************************************
  // apb read path
  // ****************************************************************
  always_comb
  begin
    mapped = 1'b1;
    case (PADDR)
      hpf_pkg::ADR_HOST_CTRL: rmux = host_ctrl_reg;
      hpf_pkg::ADR_SYS_CTRL:  rmux = sys_ctrl_reg;
      hpf_pkg::ADR_IN1:       rmux = in1_reg;
      hpf_pkg::ADR_OUT1:      rmux = out1_reg;
      hpf_pkg::ADR_STS1:      rmux = sts1_reg;
      hpf_pkg::ADR_IN2:       rmux = in2_reg;
      hpf_pkg::ADR_OUT2:      rmux = out2_reg;
      hpf_pkg::ADR_STS2:      rmux = sts2_reg;
      hpf_pkg::ADR_PORT4:     rmux = port4_reg;
      hpf_pkg::ADR_IRQ_EN:    rmux = irq_en_reg;
      hpf_pkg::ADR_GATE_PIN:  rmux = gate_pin_reg;
      default:
      begin
        rmux   = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end
  // read data captured in setup and held through the access
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      PRDATA <= 32'h0000_0000;
    else if (setup && !PWRITE)
      PRDATA <= {24'h00_0000, rmux};
  end
  // ****************************************************************
  // host data bus and outputs
  // ****************************************************************
  // bus data from a flop; the enable follows the read strobe
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      HOST_DATA_OUT <= 8'h00;
    else if (ch1_now)
      HOST_DATA_OUT <= hs.addr ? sts1_reg : out1_reg;
    else if (ch2_now)
      HOST_DATA_OUT <= hs.addr ? sts2_reg : out2_reg;
  end
  assign HOST_DATA_OE_N = !rd_active;
  // gate pin: fast level in fast mode, else the software data value
  assign ADDR20_GATE_OUT  = fast_en ? gate_q : gate_pin_reg[hpf_pkg::DVAL_BIT];
  assign ADDR20_GATE_OE_N = !gate_pin_reg[hpf_pkg::DIR_BIT];
  // host requests only reach the pins in slave mode
  assign HOST_REQ_A = host_en && port4_reg[hpf_pkg::REQ_A];
  assign HOST_REQ_B = host_en && port4_reg[hpf_pkg::REQ_B];
  assign HOST_REQ_C = host_en && port4_reg[hpf_pkg::REQ_C];
  assign RX_FULL_IRQ_CH1 = irq_en_reg[0] && sts1_reg[hpf_pkg::RXF_BIT];
  assign RX_FULL_IRQ_CH2 = irq_en_reg[1] && sts2_reg[hpf_pkg::RXF_BIT];
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_port_off: assert property (!host_en |-> HOST_DATA_OE_N ##1
    !(wr1 || wr2))
    else $error("host port active while disabled");
  a_read_drive: assert property (rd_active && ch1_now && !hs.addr
    |=> HOST_DATA_OUT == $past(out1_reg))
    else $error("ch1 read not driven");
  a_ch2_load: assert property (wr2 |=> in2_reg == $past(prev_reg.data)
    && sts2_reg[hpf_pkg::RXF_BIT])
    else $error("ch2 write not loaded");
  a_both_idle: assert property (!prev_reg.rd_n && !prev_reg.wr_n
    |-> !wr1 && !wr2)
    else $error("both strobes treated as access");
  a_full_irq: assert property (wr1 && raise1 && irq_en_reg[0]
    |=> RX_FULL_IRQ_CH1)
    else $error("ch1 full interrupt missing");
  a_cd_latch: assert property (wr1 |=> sts1_reg[hpf_pkg::CD_BIT] ==
    $past(prev_reg.addr))
    else $error("command bit not latched");
  a_req_set: assert property (!port4_reg[hpf_pkg::REQ_C] && !(wr_acc &&
    PADDR == hpf_pkg::ADR_PORT4 && read0_reg[hpf_pkg::REQ_C])
    |=> !port4_reg[hpf_pkg::REQ_C])
    else $error("request latch set without read zero");
  a_req_clr1: assert property (host_clr[hpf_pkg::REQ_A] && !wr_acc
    |=> !port4_reg[hpf_pkg::REQ_A] && !port4_reg[hpf_pkg::REQ_B])
    else $error("ch1 read left request set");
  a_req_clr2: assert property (host_clr[hpf_pkg::REQ_C] && !wr_acc
    |=> !port4_reg[hpf_pkg::REQ_C])
    else $error("ch2 read left request set");
  c_cmd_write: cover property (wr1 && prev_reg.addr);
  c_host_read: cover property (rd_fall && ch2_now);
  c_req_cycle: cover property ($rose(HOST_REQ_A) ##[1:50] $fell(HOST_REQ_A));
endmodule

// [rtl/hpf_pkg.sv]
// constants and carrier types shared by the host port files
package hpf_pkg;
  // register byte addresses on the apb side
  localparam logic [15:0] ADR_HOST_CTRL = 16'hfff0;
  localparam logic [15:0] ADR_SYS_CTRL  = 16'hfff4;
  localparam logic [15:0] ADR_IN1       = 16'hff00;
  localparam logic [15:0] ADR_OUT1      = 16'hff04;
  localparam logic [15:0] ADR_STS1      = 16'hff08;
  localparam logic [15:0] ADR_IN2       = 16'hff0c;
  localparam logic [15:0] ADR_OUT2      = 16'hff10;
  localparam logic [15:0] ADR_STS2      = 16'hff14;
  localparam logic [15:0] ADR_PORT4     = 16'hff18;
  localparam logic [15:0] ADR_IRQ_EN    = 16'hff1c;
  localparam logic [15:0] ADR_GATE_PIN  = 16'hff20;
  // field positions
  localparam int HPE_BIT  = 1;  // system control: host port enable
  localparam int FGE_BIT  = 0;  // host control: fast gate enable
  localparam int CD_BIT   = 3;  // status: command/data
  localparam int RXF_BIT  = 1;  // status: input buffer full
  localparam int TXF_BIT  = 0;  // status: output buffer full
  localparam int REQ_C    = 3;  // port4 latch cleared by ch2 reads
  localparam int REQ_A    = 4;  // port4 latch cleared by ch1 reads
  localparam int REQ_B    = 5;  // port4 latch cleared by ch1 reads
  localparam int DIR_BIT  = 0;  // gate pin: direction
  localparam int DVAL_BIT = 1;  // gate pin: data value
  localparam int GATE_BIT = 1;  // data bit copied to the gate
  localparam logic [7:0] STS_USER_MASK = 8'hf4;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_GATE = 8'h02;
  // host commands decoded by the fast gate
  localparam logic [7:0] CMD_GATE = 8'hd1;
  localparam logic [7:0] CMD_NOP  = 8'hff;
  // one sample of the host pins
  typedef struct packed {
    logic       sel1_n;
    logic       sel2_n;
    logic       rd_n;
    logic       wr_n;
    logic       addr;
    logic [7:0] data;
  } hpf_pins_t;
  localparam hpf_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
endpackage

// [rtl/hpf_sync.sv]
// two-flop synchroniser for the host pin bundle
`timescale 1ns/1ns
module hpf_sync
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire hpf_pkg::hpf_pins_t din,
  output hpf_pkg::hpf_pins_t     dout
);
  hpf_pkg::hpf_pins_t meta_reg;  // first stage, read only by dout
  // strobes idle high through reset so no false edge on release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= hpf_pkg::PINS_IDLE;
      dout     <= hpf_pkg::PINS_IDLE;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule
